// [elmr_receiver.sv]
`timescale 1ns/100ps
// What this block does
// R1 - GC byte when select 0, NR when 1
// R2 - Nothing received until enable bit 2 set
// R3 - Software selects byte first, then enables
// R4 - Hunt selected stream for flag 0x7E
// R5 - Flag found sets status bit 0
// R6 - Non-flag octet clears status bit 0
// R7 - Repeated flags are idle fill
// R8 - Non-abort octet after flags starts frame
// R9 - Seven or more ones set abort bit 6
// R10 - Drop zero following five ones
// R11 - Information field stored at 0xDE..0x135
// R12 - Frame: flag, header, info, FCS, flag
// R13 - First info byte carries type code
// R14 - CRC-16 over header and info, compare FCS
// R15 - Status bit 2 shows FCS mismatch
// R16 - Message stored even when FCS fails
// R17 - Software checks bit 2 before trusting
// R18 - C/R bit copied to status bit 3
// R19 - Message type reported in bits 5:4
// R20 - Frame done sets control bit 0, read-clear
// R21 - Frame done sets status bit 1
// R22 - Interrupt only when flag and enable set
// R23 - Reset disables, clears status; re-enable rehunts
module elmr_receiver
  import elmr_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic sys_rst, // Asynchronous reset, active high
  elmr_link_if.dev link, // Overhead octets from the framer
  input wire logic [10:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic msgIrq // Message interrupt request
);

  typedef enum logic {RX_HUNT, RX_FRAME} elmr_rx_e;

  typedef struct packed {
    elmr_rx_e state;
    logic [7:0] sh;
    logic [3:0] shCnt;
    logic [2:0] ones;
    logic [7:0] acc;
    logic [3:0] accCnt;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] octCnt;
    logic [15:0] crc;
    logic pOrigin;
    logic [1:0] pKind;
    logic selNr;
    logic rxEn;
    logic irqEn;
    logic irqFlag;
    logic abortSeen;
    logic [1:0] kind;
    logic origin;
    logic chkErr;
    logic done;
    logic flagSeen;
    logic ack;
    logic [7:0] rdata;
    logic [ELMR_BUF_DEPTH-1:0][7:0] mem;
  } elmr_rx_s;

  elmr_rx_s st_r;
  elmr_rx_s st_nxt;
  logic req;
  logic [8:0] regIdx;
  logic [8:0] bufIdx;
  logic [7:0] ctlView;
  logic [7:0] statView;

  assign req = avs_read | avs_write;
  assign regIdx = avs_address[10:2];
  assign bufIdx = regIdx - ELMR_IDX_BUF_LO;
  // One wait state: read data is registered in the first cycle
  assign avs_waitrequest = req & ~st_r.ack;
  assign avs_readdata = {24'h000000, st_r.rdata};
  assign msgIrq = st_r.irqFlag & st_r.irqEn; // R22
  assign ctlView = {4'h0, st_r.selNr, st_r.rxEn, st_r.irqEn, st_r.irqFlag};
  assign statView = {1'b0, st_r.abortSeen, st_r.kind, st_r.origin, st_r.chkErr, st_r.done, st_r.flagSeen};

  always_comb
  begin
    logic b;
    logic [7:0] oct;
    logic [7:0] k;
    b = st_r.sh[0];
    oct = {b, st_r.acc[7:1]};
    k = st_r.octCnt - 8'h02;
    st_nxt = st_r;

    // ************************************************************
    // Register bus
    // ************************************************************
    st_nxt.ack = req & ~st_r.ack;
    if (req & ~st_r.ack)
    begin
      if (regIdx == ELMR_IDX_CTL)
        st_nxt.rdata = ctlView;
      else if (regIdx == ELMR_IDX_STAT)
        st_nxt.rdata = statView;
      else if (regIdx >= ELMR_IDX_BUF_LO && regIdx <= ELMR_IDX_BUF_HI)
        st_nxt.rdata = st_r.mem[bufIdx];
      else
        st_nxt.rdata = 8'h00;
    end
    if (req & st_r.ack & avs_write & (regIdx == ELMR_IDX_CTL))
    begin
      st_nxt.selNr = avs_writedata[CTL_SEL_NR]; // R1
      st_nxt.rxEn = avs_writedata[CTL_RX_EN]; // R2
      st_nxt.irqEn = avs_writedata[CTL_IRQ_EN];
    end
    // Cleared here, before the frame logic, so a new frame's set wins
    // Clear only what the read returned, so a flag set while the read waited is not lost
    if (req & st_r.ack & avs_read & (regIdx == ELMR_IDX_CTL))
      st_nxt.irqFlag = st_r.irqFlag & ~st_r.rdata[CTL_IRQ_FLAG]; // R20

    // ************************************************************
    // Bit engine: one received bit per cycle, LSB first
    // ************************************************************
    if (st_r.shCnt != 4'h0)
    begin
      st_nxt.sh = st_r.sh >> 1;
      st_nxt.shCnt = st_r.shCnt - 4'h1;
      if (b)
      begin
        st_nxt.ones = (st_r.ones == ABORT_RUN) ? st_r.ones : st_r.ones + 3'h1;
        if (st_nxt.ones == ABORT_RUN)
        begin
          st_nxt.abortSeen = 1'b1; // R9
          st_nxt.flagSeen = 1'b0;
          st_nxt.state = RX_HUNT;
        end
      end
      else
      begin
        st_nxt.ones = 3'h0;
      end

      if (~b && st_r.ones == FLAG_RUN)
      begin
        st_nxt.flagSeen = 1'b1; // R5
        // Close only on a whole octet count; the flag's first 7 bits sit in acc
        if (st_r.state == RX_FRAME && st_r.octCnt >= MIN_OCTETS && st_r.accCnt == FLAG_TAIL) // R12
        begin
          st_nxt.chkErr = (st_r.crc != {st_r.d1, st_r.d0}); // R15
          st_nxt.origin = st_r.pOrigin; // R18
          st_nxt.kind = st_r.pKind; // R19
          st_nxt.done = 1'b1; // R21
          st_nxt.irqFlag = 1'b1; // R20
        end
        // Any flag (re)opens; back-to-back flags just restart an empty frame
        st_nxt.state = RX_FRAME; // R4 R7
        st_nxt.accCnt = 4'h0;
        st_nxt.octCnt = 8'h00;
        st_nxt.crc = CRC_INIT;
      end
      else if (~b && st_r.ones == STUFF_RUN)
      begin
        st_nxt.acc = st_r.acc; // R10
      end
      else if (st_r.state == RX_FRAME && st_nxt.ones != ABORT_RUN)
      begin
        st_nxt.acc = oct;
        st_nxt.accCnt = st_r.accCnt + 4'h1;
        if (st_r.accCnt == OCT_BITS - 4'h1)
        begin
          st_nxt.accCnt = 4'h0;
          st_nxt.flagSeen = 1'b0; // R6
          if (st_r.octCnt == 8'h00)
          begin
            st_nxt.done = 1'b0; // R8
            st_nxt.abortSeen = 1'b0;
          end
          st_nxt.octCnt = (st_r.octCnt == 8'hff) ? st_r.octCnt : st_r.octCnt + 8'h01;
          // Two-octet delay keeps the FCS out of the CRC and the buffer
          st_nxt.d0 = oct;
          st_nxt.d1 = st_r.d0;
          if (st_r.octCnt >= 8'h02)
          begin
            st_nxt.crc = elmr_crc_byte(st_r.crc, st_r.d1); // R14
            if (k == 8'h00)
              st_nxt.pOrigin = st_r.d1[ADDR_CR_BIT];
            if (k == HDR_LEN)
              st_nxt.pKind = elmr_kind(st_r.d1);
            if (k >= HDR_LEN && k < HDR_LEN + 8'(ELMR_BUF_DEPTH))
              st_nxt.mem[k - HDR_LEN] = st_r.d1; // R11 R16
          end
        end
      end
    end

    // ************************************************************
    // Octet intake and enable
    // ************************************************************
    // A new octet replaces any unfinished one; frames are far apart
    if (link.ohValid & st_r.rxEn)
    begin
      st_nxt.sh = st_r.selNr ? link.nrByte : link.gcByte; // R1
      st_nxt.shCnt = OCT_BITS;
    end
    if (~st_r.rxEn)
    begin
      st_nxt.state = RX_HUNT; // R2 R23
      st_nxt.shCnt = 4'h0;
      st_nxt.ones = 3'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0; // R23
    else
      st_r <= st_nxt;
  end

endmodule : elmr_receiver

// [elmr_pkg.sv]
package elmr_pkg;

  // ************************************************************
  // Register map (indices; byte address is four times the index)
  // ************************************************************
  localparam logic [8:0] ELMR_IDX_CTL = 9'h018;
  localparam logic [8:0] ELMR_IDX_STAT = 9'h019;
  localparam logic [8:0] ELMR_IDX_BUF_LO = 9'h0de;
  localparam logic [8:0] ELMR_IDX_BUF_HI = 9'h135;
  localparam int ELMR_BUF_DEPTH = 88;

  localparam int CTL_IRQ_FLAG = 0;
  localparam int CTL_IRQ_EN = 1;
  localparam int CTL_RX_EN = 2;
  localparam int CTL_SEL_NR = 3;
  localparam int ADDR_CR_BIT = 1;

  // ************************************************************
  // Frame layout and octet values
  // ************************************************************
  localparam logic [7:0] ELMR_FLAG = 8'h7e;
  localparam logic [7:0] ELMR_ABORT_OCT = 8'hff;
  localparam logic [7:0] ELMR_ADDR_CPE = 8'h3c;
  localparam logic [7:0] ELMR_ADDR_NET = 8'h3e;
  localparam logic [7:0] ELMR_TEI = 8'h01;
  localparam logic [7:0] ELMR_CTRL = 8'h03;
  localparam logic [7:0] TYPE_CL = 8'h38;
  localparam logic [7:0] TYPE_IDLE = 8'h34;
  localparam logic [7:0] TYPE_TEST = 8'h32;
  localparam logic [7:0] TYPE_ITU = 8'h3f;
  localparam logic [1:0] KIND_TEST = 2'h0;
  localparam logic [1:0] KIND_IDLE = 2'h1;
  localparam logic [1:0] KIND_CL = 2'h2;
  localparam logic [1:0] KIND_ITU = 2'h3;
  localparam logic [7:0] INFO_SHORT = 8'h4c;
  localparam logic [7:0] INFO_LONG = 8'h52;
  localparam logic [7:0] HDR_LEN = 8'h03;
  localparam logic [7:0] MIN_OCTETS = 8'h05;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] FLAG_RUN = 3'h6;
  localparam logic [2:0] ABORT_RUN = 3'h7;
  localparam logic [3:0] OCT_BITS = 4'h8;
  localparam logic [3:0] FLAG_TAIL = 4'h7;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // ************************************************************
  // Timing: one overhead octet per E3 frame
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int E3_FRAME_NS = 125000;
  localparam int FRAME_CYC = E3_FRAME_NS / CLK_PERIOD_NS;

  // CRC-16 x16+x12+x5+1, most significant bit of the octet first
  function automatic logic [15:0] elmr_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : elmr_crc_byte

  function automatic logic [1:0] elmr_kind(input logic [7:0] code);
    case (code)
      TYPE_IDLE: return KIND_IDLE;
      TYPE_CL: return KIND_CL;
      TYPE_ITU: return KIND_ITU;
      default: return KIND_TEST;
    endcase
  endfunction : elmr_kind

  function automatic logic [7:0] elmr_info_len(input logic [7:0] code);
    return (code == TYPE_ITU) ? INFO_LONG : INFO_SHORT;
  endfunction : elmr_info_len

endpackage : elmr_pkg

// [elmr_link_if.sv]
`timescale 1ns/100ps
// ************************************************************
// Overhead octet link: one GC and one NR octet per E3 frame
// ************************************************************
interface elmr_link_if;
  logic [7:0] gcByte;
  logic [7:0] nrByte;
  logic ohValid;
  modport dev (input gcByte, input nrByte, input ohValid);
  modport far (output gcByte, output nrByte, output ohValid);
endinterface : elmr_link_if

// [elmr_sender.sv]
`timescale 1ns/100ps
module elmr_sender
  import elmr_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic sys_rst, // Asynchronous reset, active high
  elmr_link_if.far link, // Overhead octets toward the receiver
  input wire logic startReq, // Send one frame, taken when not busy
  input wire logic crBit, // Origin: 1 network, 0 customer
  input wire logic [7:0] typeCode, // First information octet
  input wire logic nrSel, // Carry the link in NR instead of GC
  input wire logic abortReq, // Abort the frame in progress
  output logic infoReq, // Takes infoData this cycle
  input wire logic [7:0] infoData, // Next information octet
  output logic busy // Frame pending or in progress
);

  typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_CLOSE, TX_ABORT} elmr_tx_e;

  typedef struct packed {
    elmr_tx_e phase;
    logic pend;
    logic cr;
    logic [7:0] typ;
    logic [7:0] k;
    logic [7:0] src;
    logic [3:0] srcCnt;
    logic stuff;
    logic [2:0] ones;
    logic [15:0] crc;
    logic [7:0] outAcc;
    logic [3:0] outCnt;
    logic [11:0] frameCnt;
    logic ohValid;
    logic [7:0] gc;
    logic [7:0] nr;
  } elmr_tx_s;

  elmr_tx_s st_r;
  elmr_tx_s st_nxt;
  logic [7:0] infoEnd;

  assign busy = st_r.pend | (st_r.phase != TX_IDLE);
  assign infoEnd = HDR_LEN + elmr_info_len(st_r.typ);
  assign link.ohValid = st_r.ohValid;
  assign link.gcByte = st_r.gc;
  assign link.nrByte = st_r.nr;

  always_comb
  begin
    logic bitOut;
    logic [7:0] oct;
    bitOut = 1'b0;
    oct = ELMR_FLAG;
    st_nxt = st_r;
    infoReq = 1'b0;

    // ************************************************************
    // Frame pacing: one octet per E3 frame
    // ************************************************************
    st_nxt.ohValid = 1'b0;
    st_nxt.frameCnt = st_r.frameCnt + 12'h001;
    if (st_r.frameCnt == 12'(FRAME_CYC - 1))
    begin
      st_nxt.frameCnt = 12'h000;
      st_nxt.ohValid = 1'b1;
      // Only right after reset can the octet be unfinished; flags fill it
      if (st_r.outCnt == OCT_BITS)
      begin
        oct = st_r.outAcc;
        st_nxt.outCnt = 4'h0;
      end
      st_nxt.gc = nrSel ? 8'h00 : oct; // R1
      st_nxt.nr = nrSel ? oct : 8'h00;
    end

    if (startReq & ~busy)
    begin
      st_nxt.pend = 1'b1;
      st_nxt.cr = crBit;
      st_nxt.typ = typeCode; // R13
    end
    if (abortReq & (st_r.phase == TX_BODY))
      st_nxt.phase = TX_ABORT;

    // ************************************************************
    // Bit serializer with zero insertion
    // ************************************************************
    if (st_r.srcCnt != 4'h0)
    begin
      if (st_r.outCnt != OCT_BITS)
      begin
        if (st_r.ones == STUFF_RUN)
        begin
          bitOut = 1'b0; // R10
          st_nxt.ones = 3'h0;
        end
        else
        begin
          bitOut = st_r.src[0];
          st_nxt.src = st_r.src >> 1;
          st_nxt.srcCnt = st_r.srcCnt - 4'h1;
          st_nxt.ones = (st_r.stuff & bitOut) ? st_r.ones + 3'h1 : 3'h0;
        end
        st_nxt.outAcc = {bitOut, st_r.outAcc[7:1]};
        st_nxt.outCnt = st_r.outCnt + 4'h1;
      end
    end
    else
    begin
      st_nxt.srcCnt = OCT_BITS;
      st_nxt.stuff = 1'b0;
      st_nxt.src = ELMR_FLAG; // R7
      case (st_r.phase)
        TX_IDLE:
        begin
          if (st_r.pend)
          begin
            st_nxt.pend = 1'b0;
            st_nxt.phase = TX_BODY;
            st_nxt.k = 8'h00;
            st_nxt.crc = CRC_INIT;
          end
        end
        TX_BODY:
        begin
          st_nxt.stuff = 1'b1;
          if (st_r.k == 8'h00)
            st_nxt.src = st_r.cr ? ELMR_ADDR_NET : ELMR_ADDR_CPE; // R12
          else if (st_r.k == 8'h01)
            st_nxt.src = ELMR_TEI;
          else if (st_r.k == 8'h02)
            st_nxt.src = ELMR_CTRL;
          else if (st_r.k == HDR_LEN)
            st_nxt.src = st_r.typ;
          else if (st_r.k < infoEnd)
          begin
            st_nxt.src = infoData;
            infoReq = 1'b1;
          end
          else if (st_r.k == infoEnd)
            st_nxt.src = st_r.crc[15:8];
          else
            st_nxt.src = st_r.crc[7:0];
          if (st_r.k < infoEnd)
            st_nxt.crc = elmr_crc_byte(st_r.crc, st_nxt.src); // R14
          st_nxt.k = st_r.k + 8'h01;
          if (st_r.k == infoEnd + 8'h01)
            st_nxt.phase = TX_CLOSE;
        end
        TX_CLOSE:
        begin
          st_nxt.phase = TX_IDLE;
        end
        TX_ABORT:
        begin
          // Eight ones, then the next flag's zero ends the abort
          st_nxt.src = ELMR_ABORT_OCT;
          st_nxt.phase = TX_IDLE;
        end
        default:
        begin
          st_nxt.phase = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : elmr_sender

// [elmr_link_monitor.sv]
`timescale 1ns/100ps
// ****
// Checks on the overhead octet link
// ****
module elmr_link_monitor
  import elmr_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset, active high
  input wire logic [7:0] gcByte, // GC lane
  input wire logic [7:0] nrByte, // NR lane
  input wire logic ohValid // Octet strobe
);
  typedef struct packed {
    logic [11:0] gap;
    logic seen;
    logic [3:0] run;
    logic longRun;
  } elmr_mon_s;
  elmr_mon_s st_r;
  elmr_mon_s st_nxt;
  logic [7:0] lane;
  logic [3:0] runAcc;
  logic [3:0] runMax;
  assign lane = gcByte | nrByte;
  // Ones are counted across octets, LSB first, as they leave on the wire
  always_comb
  begin
    st_nxt = st_r;
    runAcc = st_r.run;
    runMax = 4'h0;
    st_nxt.gap = ohValid ? 12'h000 : st_r.gap + 12'h001;
    for (int i = 0; i < 8; i++)
    begin
      runAcc = lane[i] ? runAcc + 4'h1 : 4'h0;
      runMax = (runAcc > runMax) ? runAcc : runMax;
    end
    if (ohValid)
    begin
      st_nxt.seen = 1'b1;
      st_nxt.run = runAcc;
      st_nxt.longRun = runMax > 4'h6;
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  default clocking mclk @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_quiet;
    !ohValid [*8];
  endsequence
  chk_pulse_spacing: assert property (ohValid |=> s_quiet)
    else $error("octet strobe repeated too soon");
  chk_gap_exact: assert property (ohValid && st_r.seen |-> st_r.gap == 12'(FRAME_CYC - 1))
    else $error("octet strobe came early");
  chk_gap_late: assert property (st_r.seen && st_r.gap == 12'(FRAME_CYC - 1) |-> ohValid)
    else $error("octet strobe came late");
  chk_lane_hold: assert property (!ohValid |-> $stable(gcByte) && $stable(nrByte))
    else $error("lane changed between strobes");
  chk_one_lane: assert property (ohValid |-> gcByte == 8'h00 || nrByte == 8'h00)
    else $error("both lanes carry data");
  chk_first_flag: assert property (ohValid && !st_r.seen |-> gcByte == ELMR_FLAG && nrByte == 8'h00)
    else $error("first octet is not a flag");
  chk_stuff_run: assert property (ohValid && runMax > 4'h6 |-> runMax < 4'he && (!st_r.longRun || st_r.run > 4'h6))
    else $error("unstuffed run of ones");
  chk_reset_quiet: assert property ($fell(sys_rst) |-> s_quiet)
    else $error("strobe right after reset");
endmodule : elmr_link_monitor

// [elmr_receiver_bench.sv]
`timescale 1ns/100ps
module elmr_receiver_bench
  import elmr_pkg::*;
;
  localparam logic [7:0] KCODE [4] = '{TYPE_TEST, TYPE_IDLE, TYPE_CL, TYPE_ITU};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [10:0] adr [2] = '{2{11'h000}};
  logic rd [2] = '{2{1'b0}};
  logic wr [2] = '{2{1'b0}};
  logic [31:0] wd [2] = '{2{32'h0}};
  logic [31:0] rdata [2];
  logic wt [2];
  logic irq [2];
  logic startReq = 1'b0;
  logic crBit = 1'b0;
  logic nrSel = 1'b0;
  logic abortReq = 1'b0;
  logic [7:0] typeCode = 8'h00;
  logic [7:0] infoData = 8'h00;
  logic busy;
  logic sel = 1'b0;
  logic [15:0] expQ [2][$];
  logic [7:0] ex [88];
  bit bq [$];
  int ones = 0;
  int nErrors = 0;
  int checksDone = 0;
  elmr_link_if lk ();
  elmr_link_if lk2 ();
  elmr_sender i_elmr_sender (.clk(clk), .sys_rst(sys_rst), .link(lk.far), .startReq(startReq), .crBit(crBit),
    .typeCode(typeCode), .nrSel(nrSel), .abortReq(abortReq), .infoReq(), .infoData(infoData), .busy(busy));
  elmr_receiver i_elmr_receiver (.clk(clk), .sys_rst(sys_rst), .link(lk.dev), .avs_address(adr[0]),
    .avs_read(rd[0]), .avs_write(wr[0]), .avs_writedata(wd[0]), .avs_readdata(rdata[0]),
    .avs_waitrequest(wt[0]), .msgIrq(irq[0]));
  // Second receiver is fed by the bench at a fast octet rate
  elmr_receiver i_elmr_receiver_b (.clk(clk), .sys_rst(sys_rst), .link(lk2.dev), .avs_address(adr[1]),
    .avs_read(rd[1]), .avs_write(wr[1]), .avs_writedata(wd[1]), .avs_readdata(rdata[1]),
    .avs_waitrequest(wt[1]), .msgIrq(irq[1]));
  elmr_link_monitor i_elmr_link_monitor (.clk(clk), .sys_rst(sys_rst), .gcByte(lk.gcByte),
    .nrByte(lk.nrByte), .ohValid(lk.ohValid));
  initial
  begin
    forever #25 clk = ~clk;
  end
  // ****
  // Checking
  // ****
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e)
    begin
      nErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  always @(posedge clk)
  begin
    logic [15:0] e;
    for (int u = 0; u < 2; u++)
    begin
      if (rd[u] === 1'b1 && wt[u] === 1'b0)
      begin
        e = expQ[u].pop_front();
        cmp(rdata[u] & {24'hffffff, e[15:8]}, {24'h0, e[7:0]});
      end
    end
  end
  task automatic finishTest;
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finishTest
  // ****
  // Drivers
  // ****
  // A read notes value d under mask m for the watcher
  task automatic bus(input int u, input bit w, input logic [8:0] ix, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    adr[u] <= {ix, 2'b00};
    wd[u] <= {24'h0, d};
    rd[u] <= !w;
    wr[u] <= w;
    if (!w)
      expQ[u].push_back({m, d});
    // No limit of its own: a slave that never answers is caught by the watchdog
    do
    begin
      @(posedge clk);
    end
    while (wt[u] !== 1'b0);
    rd[u] <= 1'b0;
    wr[u] <= 1'b0;
  endtask : bus
  task automatic pulses(input int k);
    repeat (k)
    begin
      @(posedge clk);
      while (lk.ohValid !== 1'b1) @(posedge clk);
    end
    repeat (10) @(posedge clk);
  endtask : pulses
  task automatic tx(input logic [7:0] v);
    @(posedge clk);
    lk2.gcByte <= sel ? 8'h00 : v;
    lk2.nrByte <= sel ? v : 8'h00;
    lk2.ohValid <= 1'b1;
    @(posedge clk);
    lk2.ohValid <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : tx
  task automatic put(input logic [7:0] v, input bit st);
    for (int i = 0; i < 8; i++)
    begin
      bq.push_back(v[i]);
      ones = (st && v[i]) ? ones + 1 : 0;
      if (ones == 5)
      begin
        bq.push_back(1'b0);
        ones = 0;
      end
    end
  endtask : put
  task automatic flush;
    logic [7:0] o;
    while (bq.size() >= 8)
    begin
      for (int i = 0; i < 8; i++) o[i] = bq.pop_front();
      tx(o);
    end
    repeat (4) @(posedge clk);
  endtask : flush
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc16
  task automatic frame(input logic [7:0] ad, input logic [7:0] ty, input bit bad);
    logic [15:0] c;
    logic [7:0] v;
    c = 16'hffff;
    put(ELMR_FLAG, 0);
    put(ELMR_FLAG, 0);
    for (int i = 0; i < ((ty == TYPE_ITU) ? 85 : 79); i++)
    begin
      v = (i == 0) ? ad : (i == 1) ? ELMR_TEI : (i == 2) ? ELMR_CTRL : (i == 3) ? ty : 8'($urandom);
      if (i > 2)
        ex[i - 3] = v;
      c = crc16(c, v);
      put(v, 1);
    end
    put(c[15:8], 1);
    put(c[7:0] ^ {7'h0, bad}, 1);
    put(ELMR_FLAG, 0);
    put(ELMR_FLAG, 0);
    flush;
  endtask : frame
  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(32'haec5));
    lk2.gcByte = 8'h00;
    lk2.nrByte = 8'h00;
    lk2.ohValid = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1, 0, ELMR_IDX_CTL, 8'h00, 8'hff);
    bus(1, 1, ELMR_IDX_STAT, 8'hff, 8'h00);
    bus(1, 0, ELMR_IDX_STAT, 8'h00, 8'hff);
    bus(1, 0, 9'h1ff, 8'h00, 8'hff);
    frame(ELMR_ADDR_NET, TYPE_CL, 0);
    bus(1, 0, ELMR_IDX_STAT, 8'h00, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      sel = i[0];
      bus(1, 1, ELMR_IDX_CTL, {4'h0, sel, 3'b110}, 8'h00);
      frame(i[1] ? ELMR_ADDR_NET : ELMR_ADDR_CPE, KCODE[i], i == 2);
      bus(1, 0, ELMR_IDX_STAT, {2'b00, i[1:0], i[1], i == 2, 2'b11}, 8'hff);
      cmp({31'h0, irq[1]}, 32'h1);
      bus(1, 1, ELMR_IDX_CTL, {4'h0, sel, 3'b100}, 8'h00);
      @(posedge clk);
      cmp({31'h0, irq[1]}, 32'h0);
      bus(1, 1, ELMR_IDX_CTL, {4'h0, sel, 3'b110}, 8'h00);
      @(posedge clk);
      cmp({31'h0, irq[1]}, 32'h1);
      bus(1, 0, ELMR_IDX_CTL, {4'h0, sel, 3'b111}, 8'hff);
      bus(1, 0, ELMR_IDX_CTL, {4'h0, sel, 3'b110}, 8'hff);
      cmp({31'h0, irq[1]}, 32'h0);
      for (int j = 0; j < (i == 3 ? 82 : 76); j++) bus(1, 0, ELMR_IDX_BUF_LO + 9'(j), ex[j], 8'hff);
    end
    sel = 1'b0;
    bus(1, 1, ELMR_IDX_CTL, 8'h06, 8'h00);
    put(ELMR_FLAG, 0);
    put(ELMR_ADDR_CPE, 1);
    put(ELMR_TEI, 1);
    flush;
    bus(1, 0, ELMR_IDX_STAT, 8'h00, 8'h03);
    put(ELMR_FLAG, 0);
    put(ELMR_FLAG, 0);
    flush;
    bus(1, 0, ELMR_IDX_STAT, 8'h01, 8'h03);
    bus(0, 1, ELMR_IDX_CTL, 8'h06, 8'h00);
    pulses(2);
    bus(0, 0, ELMR_IDX_STAT, 8'h01, 8'h01);
    nrSel <= 1'b1;
    bus(0, 1, ELMR_IDX_CTL, 8'h0e, 8'h00);
    @(posedge clk);
    startReq <= 1'b1;
    crBit <= 1'($urandom);
    typeCode <= TYPE_CL;
    @(posedge clk);
    startReq <= 1'b0;
    pulses(8);
    abortReq <= 1'b1;
    while (busy !== 1'b0) @(posedge clk);
    abortReq <= 1'b0;
    pulses(3);
    bus(0, 0, ELMR_IDX_STAT, 8'h41, 8'hff);
    bus(0, 0, ELMR_IDX_CTL, 8'h0e, 8'hff);
    cmp({31'h0, irq[0]}, 32'h0);
    finishTest;
  end
  always @(posedge clk) infoData <= 8'($urandom);
  // Run needs about 40000 cycles
  initial
  begin
    #3000000;
    nErrors++;
    finishTest;
  end
endmodule : elmr_receiver_bench
